// ### mdic_pkg.sv
package mdic_pkg;
  localparam int unsigned           REG_W              = 16;
  localparam int unsigned           ADDR_W             = 7;
  localparam logic [ADDR_W-1:0]     CLOCK_CHECK_ADDR   = 7'h45;
  localparam logic [ADDR_W-1:0]     LOGIC_CHECK_ADDR   = 7'h46;
  localparam logic [REG_W-1:0]      REG_RESET          = 16'h0000;
  // clock_check_inject_cfg fields
  localparam int unsigned           SPARE_LSB          = 4;
  localparam int unsigned           SPARE_W            = 12;
  localparam int unsigned           FREQ_HIGH_BIT      = 3;
  localparam int unsigned           FREQ_LOW_BIT       = 2;
  localparam int unsigned           AUX_WD_BIT         = 1;
  localparam int unsigned           MAIN_WD_BIT        = 0;
  // logic_check_inject_cfg fields
  localparam int unsigned           PATTERN_LSB        = 8;
  localparam int unsigned           PATTERN_W          = 2;
  localparam int unsigned           GROUP_A_BIT        = 2;
  localparam int unsigned           GROUP_B_BIT        = 1;
  localparam int unsigned           PLAIN_IO_BIT       = 0;
  localparam logic [REG_W-1:0]      LOGIC_WRITE_MASK   = 16'h0307;
  localparam logic [PATTERN_W-1:0]  PATTERN_OFF        = 2'h0;
  // readback groups and pin counts
  localparam int unsigned           GPIO_FIELD_W       = 2;
  localparam int unsigned           GROUP_A_PINS       = 3;
  localparam int unsigned           GROUP_B_PINS       = 3;
  localparam int unsigned           PLAIN_IO_PINS      = 3;
  // propagation time of each forced fault, one flip-flop stage
  localparam int unsigned           PROP_NS            = 5;
  localparam int unsigned           CLK_PERIOD_NS      = 5;
  localparam int unsigned           PROP_CYCLES        = PROP_NS / CLK_PERIOD_NS;
endpackage

// ### mdic_readback_invert.sv
`timescale 1ns/1ps
module mdic_readback_invert
  import mdic_pkg::*;
#(
  parameter int unsigned PINS = 3
) (
  input  wire logic                         invert_en_in,
  input  wire logic [PINS-1:0]              direction_out_in,
  input  wire logic [PINS*GPIO_FIELD_W-1:0] pin_value_in,
  output      logic [PINS*GPIO_FIELD_W-1:0] pin_value_out
);
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      // inputs are never inverted, only pins driven as digital outputs
      assign pin_value_out[i*GPIO_FIELD_W +: GPIO_FIELD_W] =
        (invert_en_in && direction_out_in[i]) ? ~pin_value_in[i*GPIO_FIELD_W +: GPIO_FIELD_W]
                                              : pin_value_in[i*GPIO_FIELD_W +: GPIO_FIELD_W];
    end
  endgenerate
endmodule

// ### mdic_inject_cfg.sv
`timescale 1ns/1ps
// Function
// RULE1: twelve spare read/write bits 15:4 of the clock register, no effect.
// RULE2: frequency-high inject with frequency monitor enabled forces frequency fault.
// RULE3: frequency-low inject with frequency monitor enabled forces frequency fault.
// RULE4: host never sets frequency-high and frequency-low injects together.
// RULE5: aux watchdog inject with that watchdog enabled forces its fault.
// RULE6: main clock watchdog inject with watchdog enabled forces its fault.
// RULE7: two-bit field selects checksum pattern; zero disables, 1..3 select patterns.
// RULE8: any nonzero checksum pattern forces the register-map checksum fault.
// RULE9: group-A inject inverts readback of group-A pins configured as outputs.
// RULE10: group-B inject inverts readback of group-B pins configured as outputs.
// RULE11: plain inject inverts readback of plain pins configured as outputs.
// RULE12: reserved logic register bits 15:10 and 7:3 read-only zero.
// RULE13: both registers reset to zero, all injections disabled.
// RULE14: injection with its monitor disabled forces no fault.
module mdic_inject_cfg
  import mdic_pkg::*;
(
  input  wire logic                                  clock_in,
  input  wire logic                                  sys_rst_in,
  // register port from the serial interface
  input  wire logic                                  reg_wr_en_in,
  input  wire logic [ADDR_W-1:0]                     reg_addr_in,
  input  wire logic [REG_W-1:0]                      reg_wr_data_in,
  output      logic                                  reg_hit_out,
  output      logic [REG_W-1:0]                      reg_rd_data_out,
  // monitor enables from the monitor configuration
  input  wire logic                                  main_clk_freq_monitor_en_in,
  input  wire logic                                  aux_osc_watchdog_en_in,
  input  wire logic                                  main_clk_watchdog_en_in,
  input  wire logic                                  regmap_checksum_monitor_en_in,
  // forcing requests to the monitors
  output      logic                                  main_clk_freq_fault_flag_out,
  output      logic                                  aux_osc_watchdog_fault_flag_out,
  output      logic                                  main_clk_watchdog_fault_flag_out,
  output      logic                                  regmap_checksum_fault_flag_out,
  output      logic [PATTERN_W-1:0]                  checksum_inject_pattern_sel_out,
  // gpio readback path
  input  wire logic [GROUP_A_PINS-1:0]               group_a_pin_direction_in,
  input  wire logic [GROUP_A_PINS*GPIO_FIELD_W-1:0]  group_a_pin_value_in,
  output      logic [GROUP_A_PINS*GPIO_FIELD_W-1:0]  group_a_pin_value_out,
  input  wire logic [GROUP_B_PINS-1:0]               group_b_pin_direction_in,
  input  wire logic [GROUP_B_PINS*GPIO_FIELD_W-1:0]  group_b_pin_value_in,
  output      logic [GROUP_B_PINS*GPIO_FIELD_W-1:0]  group_b_pin_value_out,
  input  wire logic [PLAIN_IO_PINS-1:0]              plain_io_pin_direction_in,
  input  wire logic [PLAIN_IO_PINS*GPIO_FIELD_W-1:0] plain_io_pin_value_in,
  output      logic [PLAIN_IO_PINS*GPIO_FIELD_W-1:0] plain_io_pin_value_out
);

  // stored registers
  logic [REG_W-1:0]     clock_check_inject_cfg_r;
  logic [REG_W-1:0]     logic_check_inject_cfg_r;

  // decoded fields
  logic                 freq_high_inject_en;
  logic                 freq_low_inject_en;
  logic                 aux_osc_watchdog_inject_en;
  logic                 main_clk_watchdog_inject_en;
  logic [PATTERN_W-1:0] checksum_inject_pattern_sel;
  logic                 group_a_readback_invert_en;
  logic                 group_b_readback_invert_en;
  logic                 plain_io_readback_invert_en;
  logic [SPARE_W-1:0]   spare_bits;

  // address decode
  logic                 addr_clock_sel;
  logic                 addr_logic_sel;
  logic                 clock_wr_sel;
  logic                 logic_wr_sel;

  // force requests ahead of the flag flops
  logic                 freq_force_req;
  logic                 aux_wd_force_req;
  logic                 main_wd_force_req;
  logic                 checksum_force_req;

  // read images with reserved positions tied low
  logic [REG_W-1:0]     clock_rd_image;
  logic [REG_W-1:0]     logic_rd_image;

  // one decode shared by the write strobes, the hit flag and the read mux
  assign addr_clock_sel = (reg_addr_in == CLOCK_CHECK_ADDR);
  assign addr_logic_sel = (reg_addr_in == LOGIC_CHECK_ADDR);
  assign clock_wr_sel   = reg_wr_en_in && addr_clock_sel;
  assign logic_wr_sel   = reg_wr_en_in && addr_logic_sel;
  assign spare_bits     = clock_check_inject_cfg_r[SPARE_LSB +: SPARE_W]; // [RULE1]

  // spare bits are stored whole so the checksum sees them
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      clock_check_inject_cfg_r <= REG_RESET; // [RULE13]
    end else if (clock_wr_sel) begin
      clock_check_inject_cfg_r <= reg_wr_data_in; // [RULE1]
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      logic_check_inject_cfg_r <= REG_RESET; // [RULE13]
    end else if (logic_wr_sel) begin
      logic_check_inject_cfg_r <= reg_wr_data_in & LOGIC_WRITE_MASK; // [RULE12]
    end
  end

  assign freq_high_inject_en         = clock_check_inject_cfg_r[FREQ_HIGH_BIT];
  assign freq_low_inject_en          = clock_check_inject_cfg_r[FREQ_LOW_BIT];
  assign aux_osc_watchdog_inject_en  = clock_check_inject_cfg_r[AUX_WD_BIT];
  assign main_clk_watchdog_inject_en = clock_check_inject_cfg_r[MAIN_WD_BIT];
  assign checksum_inject_pattern_sel = logic_check_inject_cfg_r[PATTERN_LSB +: PATTERN_W]; // [RULE7]
  assign group_a_readback_invert_en  = logic_check_inject_cfg_r[GROUP_A_BIT];
  assign group_b_readback_invert_en  = logic_check_inject_cfg_r[GROUP_B_BIT];
  assign plain_io_readback_invert_en = logic_check_inject_cfg_r[PLAIN_IO_BIT];

  assign reg_hit_out = addr_clock_sel || addr_logic_sel;

  // spare bits only feed the readback, so the checksum covers them
  always_comb begin
    clock_rd_image                           = REG_RESET;
    clock_rd_image[SPARE_LSB +: SPARE_W]     = spare_bits; // [RULE1]
    clock_rd_image[FREQ_HIGH_BIT]            = freq_high_inject_en;
    clock_rd_image[FREQ_LOW_BIT]             = freq_low_inject_en;
    clock_rd_image[AUX_WD_BIT]               = aux_osc_watchdog_inject_en;
    clock_rd_image[MAIN_WD_BIT]              = main_clk_watchdog_inject_en;
  end

  // a stray stored bit in a reserved position can never leak out
  always_comb begin
    logic_rd_image                           = REG_RESET; // [RULE12]
    logic_rd_image[PATTERN_LSB +: PATTERN_W] = checksum_inject_pattern_sel; // [RULE7]
    logic_rd_image[GROUP_A_BIT]              = group_a_readback_invert_en;
    logic_rd_image[GROUP_B_BIT]              = group_b_readback_invert_en;
    logic_rd_image[PLAIN_IO_BIT]             = plain_io_readback_invert_en;
  end

  always_comb begin
    if (addr_clock_sel) begin
      reg_rd_data_out = clock_rd_image;
    end else if (addr_logic_sel) begin
      reg_rd_data_out = logic_rd_image; // [RULE12]
    end else begin
      reg_rd_data_out = REG_RESET;
    end
  end

  // both frequency injects together are a host error; either still forces the flag
  assign freq_force_req     = main_clk_freq_monitor_en_in &&
                              (freq_high_inject_en || freq_low_inject_en); // [RULE2] [RULE3] [RULE14]
  assign aux_wd_force_req   = aux_osc_watchdog_en_in && aux_osc_watchdog_inject_en; // [RULE5] [RULE14]
  assign main_wd_force_req  = main_clk_watchdog_en_in && main_clk_watchdog_inject_en; // [RULE6] [RULE14]
  // all three patterns are equally valid, so any nonzero value forces the flag
  assign checksum_force_req = regmap_checksum_monitor_en_in &&
                              (checksum_inject_pattern_sel != PATTERN_OFF); // [RULE8] [RULE14]

  // flags registered once: PROP_CYCLES after the register update
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      main_clk_freq_fault_flag_out <= 1'b0;
    end else begin
      main_clk_freq_fault_flag_out <= freq_force_req; // [RULE2] [RULE3]
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      aux_osc_watchdog_fault_flag_out <= 1'b0;
    end else begin
      aux_osc_watchdog_fault_flag_out <= aux_wd_force_req; // [RULE5]
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      main_clk_watchdog_fault_flag_out <= 1'b0;
    end else begin
      main_clk_watchdog_fault_flag_out <= main_wd_force_req; // [RULE6]
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      regmap_checksum_fault_flag_out <= 1'b0;
    end else begin
      regmap_checksum_fault_flag_out <= checksum_force_req; // [RULE8]
    end
  end

  // pattern copy lines up with the checksum flag so the checker sees both together
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      checksum_inject_pattern_sel_out <= PATTERN_OFF;
    end else begin
      checksum_inject_pattern_sel_out <= checksum_inject_pattern_sel; // [RULE7]
    end
  end

  // readback path is combinational so a read sees the inversion at once
  mdic_readback_invert #(.PINS(GROUP_A_PINS)) u_group_a ( // [RULE9]
    .invert_en_in     (group_a_readback_invert_en),
    .direction_out_in (group_a_pin_direction_in),
    .pin_value_in     (group_a_pin_value_in),
    .pin_value_out    (group_a_pin_value_out)
  );

  mdic_readback_invert #(.PINS(GROUP_B_PINS)) u_group_b ( // [RULE10]
    .invert_en_in     (group_b_readback_invert_en),
    .direction_out_in (group_b_pin_direction_in),
    .pin_value_in     (group_b_pin_value_in),
    .pin_value_out    (group_b_pin_value_out)
  );

  mdic_readback_invert #(.PINS(PLAIN_IO_PINS)) u_plain_io ( // [RULE11]
    .invert_en_in     (plain_io_readback_invert_en),
    .direction_out_in (plain_io_pin_direction_in),
    .pin_value_in     (plain_io_pin_value_in),
    .pin_value_out    (plain_io_pin_value_out)
  );

endmodule

// ### mdic_inject_cfg_monitor.sv
`timescale 1ns/1ps
module mdic_inject_cfg_monitor
  import mdic_pkg::*;
(
  input wire logic                  clock_in,
  input wire logic                  sys_rst_in,
  input wire logic                  reg_wr_en_in,
  input wire logic [ADDR_W-1:0]     reg_addr_in,
  input wire logic [REG_W-1:0]      reg_wr_data_in,
  input wire logic [REG_W-1:0]      reg_rd_data_out,
  input wire logic                  main_clk_freq_monitor_en_in,
  input wire logic                  aux_osc_watchdog_en_in,
  input wire logic                  main_clk_watchdog_en_in,
  input wire logic                  regmap_checksum_monitor_en_in,
  input wire logic                  main_clk_freq_fault_flag_out,
  input wire logic                  aux_osc_watchdog_fault_flag_out,
  input wire logic                  main_clk_watchdog_fault_flag_out,
  input wire logic                  regmap_checksum_fault_flag_out,
  input wire logic [PATTERN_W-1:0]  checksum_inject_pattern_sel_out,
  input wire logic [2:0]            group_a_pin_direction_in,
  input wire logic [5:0]            group_a_pin_value_in,
  input wire logic [5:0]            group_a_pin_value_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire w45 = reg_wr_en_in && (reg_addr_in == CLOCK_CHECK_ADDR);
  wire w46 = reg_wr_en_in && (reg_addr_in == LOGIC_CHECK_ADDR);
  property p_freq; w45 && reg_wr_data_in[3:2] != 2'h0 ##1 main_clk_freq_monitor_en_in |=> main_clk_freq_fault_flag_out; endproperty
  a_freq: assert property (p_freq) else $error("frequency flag not forced");
  property p_aux; w45 && reg_wr_data_in[1] ##1 aux_osc_watchdog_en_in |=> aux_osc_watchdog_fault_flag_out; endproperty
  a_aux: assert property (p_aux) else $error("aux watchdog flag not forced");
  property p_mwd; w45 && reg_wr_data_in[0] ##1 main_clk_watchdog_en_in |=> main_clk_watchdog_fault_flag_out; endproperty
  a_mwd: assert property (p_mwd) else $error("main watchdog flag not forced");
  property p_cs; w46 && reg_wr_data_in[9:8] != 2'h0 ##1 regmap_checksum_monitor_en_in |=> regmap_checksum_fault_flag_out; endproperty
  a_cs: assert property (p_cs) else $error("checksum flag not forced");
  property p_off; !main_clk_freq_monitor_en_in |=> !main_clk_freq_fault_flag_out; endproperty
  a_off: assert property (p_off) else $error("flag forced while monitor off");
  property p_sel; w46 ##2 1'b1 |-> checksum_inject_pattern_sel_out == $past(reg_wr_data_in[9:8], 2); endproperty
  a_sel: assert property (p_sel) else $error("pattern select wrong");
  property p_rsv; reg_addr_in == LOGIC_CHECK_ADDR |-> (reg_rd_data_out & ~LOGIC_WRITE_MASK) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_pass; group_a_pin_direction_in == 3'h0 |-> group_a_pin_value_out == group_a_pin_value_in; endproperty
  a_pass: assert property (p_pass) else $error("input pin readback altered");
  property p_rst; disable iff (1'b0) sys_rst_in |=> checksum_inject_pattern_sel_out == 2'h0 && !(main_clk_freq_fault_flag_out
    || aux_osc_watchdog_fault_flag_out || main_clk_watchdog_fault_flag_out || regmap_checksum_fault_flag_out); endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule

// ### mdic_host_model.sv
`timescale 1ns/1ps
module mdic_host_model
  import mdic_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic [REG_W-1:0]  reg_rd_data_in,
  output      logic              reg_wr_en_out = 1'b0,
  output      logic [ADDR_W-1:0] reg_addr_out = 7'h00,
  output      logic [REG_W-1:0]  reg_wr_data_out = 16'h0000
);
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
    logic [REG_W-1:0] v;
    v = d;
    // never both frequency injects at once, the low one is dropped
    if (a == CLOCK_CHECK_ADDR && v[FREQ_HIGH_BIT]) v[FREQ_LOW_BIT] = 1'b0;
    @(negedge clock_in);
    reg_wr_en_out = 1'b1;
    reg_addr_out = a;
    reg_wr_data_out = v;
    @(negedge clock_in);
    reg_wr_en_out = 1'b0;
    reg_wr_data_out = ~v;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
    @(negedge clock_in);
    reg_addr_out = a;
    #1 d = reg_rd_data_in;
  endtask
endmodule

// ### tb_mdic_inject_cfg.sv
`timescale 1ns/1ps
module tb_mdic_inject_cfg
  import mdic_pkg::*;
;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, we, hit;
  logic [6:0] ad;
  logic [15:0] wd, rdd;
  logic [3:0] en, flg;
  logic [1:0] sel;
  logic [2:0] dir;
  logic [5:0] va, vb, vp, oa, ob, op;
  int n_mismatch = 0, checks_done = 0;
  always #2.5 clock_in = ~clock_in;
  mdic_host_model mdic_host_model_i (.clock_in, .reg_rd_data_in(rdd), .reg_wr_en_out(we), .reg_addr_out(ad),
    .reg_wr_data_out(wd));
  mdic_inject_cfg mdic_inject_cfg_i (.clock_in, .sys_rst_in, .reg_wr_en_in(we), .reg_addr_in(ad),
    .reg_wr_data_in(wd), .reg_hit_out(hit), .reg_rd_data_out(rdd), .main_clk_freq_monitor_en_in(en[3]),
    .aux_osc_watchdog_en_in(en[2]), .main_clk_watchdog_en_in(en[1]), .regmap_checksum_monitor_en_in(en[0]),
    .main_clk_freq_fault_flag_out(flg[3]), .aux_osc_watchdog_fault_flag_out(flg[2]),
    .main_clk_watchdog_fault_flag_out(flg[1]), .regmap_checksum_fault_flag_out(flg[0]),
    .checksum_inject_pattern_sel_out(sel), .group_a_pin_direction_in(dir), .group_a_pin_value_in(va),
    .group_a_pin_value_out(oa), .group_b_pin_direction_in(dir), .group_b_pin_value_in(vb),
    .group_b_pin_value_out(ob), .plain_io_pin_direction_in(dir), .plain_io_pin_value_in(vp),
    .plain_io_pin_value_out(op));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] r;
    mdic_host_model_i.rd(a, r);
    chk(r, exp);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    en = 4'h0;
    dir = 3'h0;
    va = 6'h2d;
    vb = 6'h1b;
    vp = 6'h36;
    repeat (5) @(negedge clock_in);
    sys_rst_in = 1'b0;
    rdc(CLOCK_CHECK_ADDR, REG_RESET);
    rdc(LOGIC_CHECK_ADDR, REG_RESET);
    chk({12'h000, flg}, 16'h0000);
    en = 4'hf;
    mdic_host_model_i.wr(CLOCK_CHECK_ADDR, 16'hfff0);
    rdc(CLOCK_CHECK_ADDR, 16'hfff0);
    chk({15'h0000, hit}, 16'h0001);
    chk({12'h000, flg}, 16'h0000);
    for (int b = 0; b < 4; b++) begin
      mdic_host_model_i.wr(CLOCK_CHECK_ADDR, 16'h0001 << b);
      @(negedge clock_in);
      chk({12'h000, flg}, b > 1 ? 16'h0008 : 16'h0002 << b);
    end
    // monitors off first, injection must wait for them
    en = 4'h0;
    mdic_host_model_i.wr(CLOCK_CHECK_ADDR, 16'h000b);
    @(negedge clock_in);
    chk({12'h000, flg}, 16'h0000);
    en = 4'hf;
    @(negedge clock_in);
    chk({12'h000, flg}, 16'h000e);
    mdic_host_model_i.wr(CLOCK_CHECK_ADDR, 16'h0000);
    mdic_host_model_i.wr(7'h47, 16'hffff);
    rdc(CLOCK_CHECK_ADDR, 16'h0000);
    for (int p = 0; p < 4; p++) begin
      mdic_host_model_i.wr(LOGIC_CHECK_ADDR, 16'hfcf8 | 16'(p << 8));
      @(negedge clock_in);
      chk({10'h000, flg, sel}, {10'h000, 3'b000, p != 0, 2'(p)});
      rdc(LOGIC_CHECK_ADDR, 16'(p << 8));
    end
    en = 4'he;
    @(negedge clock_in);
    chk({12'h000, flg}, 16'h0000);
    dir = 3'b101;
    for (int g = 0; g < 3; g++) begin
      mdic_host_model_i.wr(LOGIC_CHECK_ADDR, 16'h0004 >> g);
      chk({10'h000, oa}, {10'h000, va ^ (g == 0 ? 6'h33 : 6'h00)});
      chk({10'h000, ob}, {10'h000, vb ^ (g == 1 ? 6'h33 : 6'h00)});
      chk({10'h000, op}, {10'h000, vp ^ (g == 2 ? 6'h33 : 6'h00)});
    end
    // reset in mid-run with injects live must clear everything again
    mdic_host_model_i.wr(CLOCK_CHECK_ADDR, 16'h000f);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    sys_rst_in = 1'b0;
    rdc(CLOCK_CHECK_ADDR, REG_RESET);
    rdc(LOGIC_CHECK_ADDR, REG_RESET);
    chk({12'h000, flg}, 16'h0000);
    chk({10'h000, op}, {10'h000, vp});
    rdc(7'h00, 16'h0000);
    chk({15'h0000, hit}, 16'h0000);
    complete_run();
  end
endmodule
bind mdic_inject_cfg mdic_inject_cfg_monitor mdic_inject_cfg_monitor_i (.clock_in, .sys_rst_in, .reg_wr_en_in,
  .reg_addr_in, .reg_wr_data_in, .reg_rd_data_out, .main_clk_freq_monitor_en_in, .aux_osc_watchdog_en_in,
  .main_clk_watchdog_en_in, .regmap_checksum_monitor_en_in, .main_clk_freq_fault_flag_out,
  .aux_osc_watchdog_fault_flag_out, .main_clk_watchdog_fault_flag_out, .regmap_checksum_fault_flag_out,
  .checksum_inject_pattern_sel_out, .group_a_pin_direction_in, .group_a_pin_value_in, .group_a_pin_value_out);
